/* File: dpch_top.sv */
// Contract
// - Each channel counts every pulse at rates up to 128 Hz, and the source stays within that.
// - A pulse standing longer than 1 ms counts once, and the source holds pulses that long.
// - While hold is high both counters stay frozen except for a clear, and pulses are ignored.
// - When hold goes low counting resumes from the frozen values.
// - A hold input left open is taken as not holding.
// - Each counter holds values up to 9,999,999.
// - The right button clears both counters together.
// - On a dual unit each left button press toggles the shown channel, and the display marks which.
// - One or two channels count, as the fitted base unit says.
`timescale 1ns/1ps
`include "dpch_defines.svh"

// ************************************************************
// Dual pulse counter with hold, clear and display select.
// ************************************************************
module dpch_top #(
  parameter int MIN_PULSE_CYC = `DPCH_MIN_PULSE_CYC,
  parameter int DEBOUNCE_CYC = `DPCH_DEBOUNCE_CYC,
  parameter int COUNT_MAX = `DPCH_COUNT_MAX
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic first_pulse_in,
  input wire logic second_pulse_in,
  input wire logic hold_in,
  input wire logic clear_btn_in,
  input wire logic select_btn_in,
  input wire logic dual_unit_in,
  output logic [`DPCH_COUNT_W-1:0] shown_count_out,
  output logic shown_second_out,
  output logic shown_overflow_out,
  output logic first_overflow_out,
  output logic second_overflow_out
);

  // Refuse a debounce count the timer cannot hold.
  initial begin
    if (DEBOUNCE_CYC < 1 || DEBOUNCE_CYC >= (1 << `DPCH_TIMER_W)) begin
      $error("Debounce count out of range.");
    end
    if (COUNT_MAX < 1 || COUNT_MAX >= (1 << `DPCH_COUNT_W)) begin
      $error("Count limit out of range.");
    end
  end

  localparam int NIN = 6;
  localparam logic [`DPCH_TIMER_W-1:0] DB_CYC = `DPCH_TIMER_W'(DEBOUNCE_CYC);

  // ************************************************************
  // Input synchronisers.
  // ************************************************************

  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q, s2_q, s3_q;
  logic [NIN-1:0] stable_q, stable_d;

  // Bit map: 0 and 1 pulses, 2 hold, 3 clear, 4 select, 5 base unit.
  assign raw = {dual_unit_in, select_btn_in, clear_btn_in, hold_in,
                second_pulse_in, first_pulse_in};

  // Three stages; a change counts when stages two and three agree.
  // Only stage two reads stage one, which may still be settling.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      stable_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      stable_q <= stable_d;
    end
  end

  // Accept a new level once the last two stages agree.
  always_comb begin
    stable_d = stable_q;
    for (int i = 0; i < NIN; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        stable_d[i] = s3_q[i];
      end
    end
  end

  // ************************************************************
  // Button debounce.
  // ************************************************************

  logic [1:0] btn;
  logic [1:0] btn_press;

  assign btn = stable_q[4:3];

  generate
    for (genvar b = 0; b < 2; b++) begin : g_db
      logic lvl_q, lvl_d;
      logic [`DPCH_TIMER_W-1:0] tmr_q, tmr_d;
      // Level must stand for the debounce time before it is taken.
      // The timer restarts whenever the level agrees again, so bounces never add up.
      always_comb begin
        lvl_d = lvl_q;
        tmr_d = '0;
        if (btn[b] != lvl_q) begin
          tmr_d = tmr_q + `DPCH_TIMER_W'(1);
          if (tmr_q >= DB_CYC) begin
            lvl_d = btn[b];
            tmr_d = '0;
          end
        end
      end
      always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
          lvl_q <= 1'b0;
          tmr_q <= '0;
        end else begin
          lvl_q <= lvl_d;
          tmr_q <= tmr_d;
        end
      end
      // One pulse per press, on the debounced rising edge.
      assign btn_press[b] = lvl_d & ~lvl_q;
    end
  endgenerate

  // ************************************************************
  // Channels.
  // ************************************************************

  logic hold;
  logic dual;

  // Open hold input is pulled low outside, so low means count.
  // A pulse that qualifies while hold is high is dropped, not counted later.
  assign hold = stable_q[2];
  assign dual = stable_q[5];

  dpch_chan_if ch_a ();
  dpch_chan_if ch_b ();

  // Both channels share hold and clear; the second runs only on a dual unit.
  // Sharing one clear strobe makes both counts drop in the same cycle.
  assign ch_a.pulse = stable_q[0];
  assign ch_b.pulse = stable_q[1];
  assign ch_a.run = ~hold;
  assign ch_b.run = ~hold & dual;
  assign ch_a.clear = btn_press[0];
  assign ch_b.clear = btn_press[0];

  dpch_channel #(
    .MIN_PULSE_CYC(MIN_PULSE_CYC),
    .COUNT_MAX(COUNT_MAX)
  ) u_first (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ch(ch_a.chan)
  );

  dpch_channel #(
    .MIN_PULSE_CYC(MIN_PULSE_CYC),
    .COUNT_MAX(COUNT_MAX)
  ) u_second (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ch(ch_b.chan)
  );

  // ************************************************************
  // Display selection.
  // ************************************************************

  dpch_pkg::dpch_show_e show_q, show_d;
  logic [`DPCH_COUNT_W-1:0] disp_q, disp_d;
  logic dovf_q, dovf_d;
  // Per-channel flags are kept in their own registers for the status pins.
  logic ovf_a_q, ovf_b_q;

  // True when the selection points at the second channel; the toggle, count and flag paths use it.
  function automatic logic shows_second(input dpch_pkg::dpch_show_e sel);
    return sel == dpch_pkg::DPCH_SHOW_SECOND;
  endfunction

  // Left button toggles; a single-channel unit always shows the first.
  // The display follows the selection one cycle late, far below what a reader sees.
  always_comb begin
    show_d = show_q;
    if (!dual) begin
      show_d = dpch_pkg::DPCH_SHOW_FIRST;
    end else if (btn_press[1]) begin
      show_d = shows_second(show_q) ?
               dpch_pkg::DPCH_SHOW_FIRST : dpch_pkg::DPCH_SHOW_SECOND;
    end
    disp_d = shows_second(show_q) ? ch_b.count : ch_a.count;
    dovf_d = shows_second(show_q) ? ch_b.overflow : ch_a.overflow;
  end

  // Display registers.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      show_q <= dpch_pkg::DPCH_SHOW_FIRST;
      disp_q <= '0;
      dovf_q <= 1'b0;
      ovf_a_q <= 1'b0;
      ovf_b_q <= 1'b0;
    end else begin
      show_q <= show_d;
      disp_q <= disp_d;
      dovf_q <= dovf_d;
      ovf_a_q <= ch_a.overflow;
      ovf_b_q <= ch_b.overflow;
    end
  end

  // Every output comes straight from a flip-flop.
  assign shown_count_out = disp_q;
  assign shown_second_out = show_q;
  assign shown_overflow_out = dovf_q;
  assign first_overflow_out = ovf_a_q;
  assign second_overflow_out = ovf_b_q;

endmodule // dpch_top

/* File: dpch_defines.svh */
`ifndef DPCH_DEFINES_SVH
`define DPCH_DEFINES_SVH

// ************************************************************
// Timing figures and counter limits.
// ************************************************************

// Clock period in nanoseconds (200 MHz).
`define DPCH_CLK_PERIOD_NS 5
// Shortest accepted pulse width in microseconds.
`define DPCH_MIN_PULSE_US 1000
// Cycles a pulse must stand before it counts, rounded up.
`define DPCH_MIN_PULSE_CYC \
  ((`DPCH_MIN_PULSE_US * 1000 + `DPCH_CLK_PERIOD_NS - 1) / `DPCH_CLK_PERIOD_NS)
// Button debounce time in microseconds.
`define DPCH_DEBOUNCE_US 10000
// Debounce time in cycles, rounded up; nanoseconds keep the product inside 32 bits.
`define DPCH_DEBOUNCE_CYC \
  ((`DPCH_DEBOUNCE_US * 1000 + `DPCH_CLK_PERIOD_NS - 1) / `DPCH_CLK_PERIOD_NS)
// Highest count a channel holds before overflow.
`define DPCH_COUNT_MAX 9999999
// Width of the binary count.
`define DPCH_COUNT_W 24
// Width of the qualification timers.
`define DPCH_TIMER_W 22

`endif

/* File: dpch_pkg.sv */
package dpch_pkg;

  // Display selection, which channel is shown.
  typedef enum logic {
    DPCH_SHOW_FIRST = 1'h0,
    DPCH_SHOW_SECOND = 1'h1
  } dpch_show_e;

endpackage

/* File: dpch_chan_if.sv */
`timescale 1ns/1ps
`include "dpch_defines.svh"

// ************************************************************
// Carrier between the top and one channel counter.
// ************************************************************
interface dpch_chan_if;
  logic pulse;
  logic run;
  logic clear;
  logic [`DPCH_COUNT_W-1:0] count;
  logic overflow;
  modport top (output pulse, output run, output clear, input count, input overflow);
  modport chan (input pulse, input run, input clear, output count, output overflow);
endinterface

/* File: dpch_channel.sv */
`timescale 1ns/1ps
`include "dpch_defines.svh"

// ************************************************************
// One pulse counter channel with width qualification.
// ************************************************************
module dpch_channel #(
  parameter int MIN_PULSE_CYC = `DPCH_MIN_PULSE_CYC,
  parameter int COUNT_MAX = `DPCH_COUNT_MAX
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  dpch_chan_if.chan ch
);

  localparam logic [`DPCH_TIMER_W-1:0] MIN_CYC = `DPCH_TIMER_W'(MIN_PULSE_CYC);
  localparam logic [`DPCH_COUNT_W-1:0] CMAX = `DPCH_COUNT_W'(COUNT_MAX);

  // Refuse a width the timer cannot hold.
  initial begin
    if (MIN_PULSE_CYC < 1 || MIN_PULSE_CYC >= (1 << `DPCH_TIMER_W)) begin
      $error("Pulse width count out of range.");
    end
    if (COUNT_MAX < 1 || COUNT_MAX >= (1 << `DPCH_COUNT_W)) begin
      $error("Count limit out of range.");
    end
  end

  logic [`DPCH_TIMER_W-1:0] wid_q, wid_d;
  logic taken_q, taken_d;
  logic [`DPCH_COUNT_W-1:0] cnt_q, cnt_d;
  logic ovf_q, ovf_d;

  // A pulse counts once when it has stood longer than the minimum width.
  always_comb begin
    wid_d = wid_q;
    taken_d = taken_q;
    cnt_d = cnt_q;
    ovf_d = ovf_q;
    if (!ch.pulse) begin
      wid_d = '0;
      taken_d = 1'b0;
    end else if (!taken_q) begin
      wid_d = wid_q + `DPCH_TIMER_W'(1);
    end
    if (ch.pulse && !taken_q && wid_q >= MIN_CYC) begin
      taken_d = 1'b1;
      if (ch.run) begin
        if (cnt_q == CMAX) begin
          cnt_d = '0;
          ovf_d = 1'b1;
        end else begin
          cnt_d = cnt_q + `DPCH_COUNT_W'(1);
        end
      end
    end
    if (ch.clear) begin
      cnt_d = '0;
      // A wrap in the same cycle as a clear still leaves its flag set.
      ovf_d = taken_d && !taken_q && ch.run && cnt_q == CMAX;
    end
  end

  // State registers.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wid_q <= '0;
      taken_q <= 1'b0;
      cnt_q <= '0;
      ovf_q <= 1'b0;
    end else begin
      wid_q <= wid_d;
      taken_q <= taken_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  assign ch.count = cnt_q;
  assign ch.overflow = ovf_q;

endmodule // dpch_channel

/* File: dpch_top_props.sv */
`timescale 1ns/1ps
`include "dpch_defines.svh"

// ************************************************************
// Port checker for the dual pulse counter.
// ************************************************************
module dpch_top_props #(
  parameter int MIN_PULSE_CYC = 4,
  parameter int DEBOUNCE_CYC = 8,
  parameter int COUNT_MAX = `DPCH_COUNT_MAX
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic first_pulse_in,
  input wire logic second_pulse_in,
  input wire logic hold_in,
  input wire logic clear_btn_in,
  input wire logic select_btn_in,
  input wire logic dual_unit_in,
  input wire logic [`DPCH_COUNT_W-1:0] shown_count_out,
  input wire logic shown_second_out,
  input wire logic shown_overflow_out,
  input wire logic first_overflow_out,
  input wire logic second_overflow_out
);
  logic [2:0] v_q, v_qq;
  logic [7:0] clr_q;
  logic quiet;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Display state history, so changes of selection are not taken for counts.
  always_ff @(posedge clk_in) begin
    v_q <= {shown_second_out, first_overflow_out, second_overflow_out};
    v_qq <= v_q;
    clr_q <= (!rst_n_in || !clear_btn_in) ? 8'h00 : clr_q + {7'h00, clr_q != 8'hFF};
  end
  assign quiet = v_q == {shown_second_out, first_overflow_out, second_overflow_out} && v_qq == v_q;
  a_count_bound: assert property (shown_count_out <= COUNT_MAX)
    else $error("shown count above its maximum");
  a_count_step: assert property (quiet && $past(quiet) |-> shown_count_out == 24'h0 ||
    shown_count_out - $past(shown_count_out) <= 24'h1) else $error("count jumped");
  a_hold_freeze: assert property (hold_in [*8] ##0 quiet |-> $stable(shown_count_out) ||
    shown_count_out == 24'h0) else $error("count moved while held");
  a_clear_zero: assert property (clr_q == DEBOUNCE_CYC + 8 |-> shown_count_out == 24'h0 &&
    !first_overflow_out && !second_overflow_out) else $error("clear missed");
  a_wrap_zero: assert property ($rose(first_overflow_out) && !shown_second_out |->
    ##[0:2] shown_count_out == 24'h0) else $error("no wrap to zero");
  a_ovf_sticky: assert property ((!clear_btn_in) [*8] ##0 first_overflow_out |=>
    first_overflow_out) else $error("overflow flag dropped");
  a_ovf_shown: assert property (quiet |-> shown_overflow_out ==
    (shown_second_out ? second_overflow_out : first_overflow_out)) else $error("wrong flag");
  a_select_cause: assert property ($changed(shown_second_out) && dual_unit_in &&
    $past(dual_unit_in) |-> $past(select_btn_in, 6)) else $error("toggle without press");
  a_single_idle: assert property ((!dual_unit_in) [*8] |-> !shown_second_out)
    else $error("second shown on single unit");
  cover property (hold_in [*8]);
  cover property ($changed(shown_second_out));
  cover property (clr_q == DEBOUNCE_CYC + 8);
  cover property ($rose(first_overflow_out));
endmodule // dpch_top_props

bind dpch_top dpch_top_props #(.MIN_PULSE_CYC(MIN_PULSE_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC),
  .COUNT_MAX(COUNT_MAX))
  u_props (.clk_in, .rst_n_in, .first_pulse_in, .second_pulse_in, .hold_in, .clear_btn_in,
  .select_btn_in, .dual_unit_in, .shown_count_out, .shown_second_out, .shown_overflow_out,
  .first_overflow_out, .second_overflow_out);

/* File: dpch_sensor_model.sv */
`timescale 1ns/1ps

// ************************************************************
// Flow sensor pulse outputs and hold controller.
// ************************************************************
module dpch_sensor_model (
  input wire logic clk_in,
  output logic first_pulse_out,
  output logic second_pulse_out,
  output logic hold_out
);
  // Idle lines rest low; the hold line stands for an open input pulled low.
  initial begin
    first_pulse_out = 1'h0;
    second_pulse_out = 1'h0;
    hold_out = 1'h0;
  end
  // One pulse on the masked channels, then a pause that keeps the rate bounded.
  task automatic pulse(input logic [1:0] mask, input int width);
    @(posedge clk_in);
    first_pulse_out <= mask[0];
    second_pulse_out <= mask[1];
    repeat (width) @(posedge clk_in);
    first_pulse_out <= 1'h0;
    second_pulse_out <= 1'h0;
    repeat (16) @(posedge clk_in);
  endtask
  // Drives the hold level.
  task automatic set_hold(input logic lvl);
    @(posedge clk_in);
    hold_out <= lvl;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // dpch_sensor_model

/* File: tb_top.sv */
`timescale 1ns/1ps

// ************************************************************
// Self-checking bench for the dual pulse counter.
// ************************************************************
module tb_top;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic clear_btn_in = 1'h0;
  logic select_btn_in = 1'h0;
  logic dual_unit_in = 1'h1;
  logic p1, p2, hold;
  logic [23:0] cnt;
  logic sec, sovf, ovf1, ovf2;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  // Clock at 200 MHz.
  always #2.5 clk_in = ~clk_in;
  dpch_sensor_model sens (.clk_in(clk_in), .first_pulse_out(p1), .second_pulse_out(p2),
    .hold_out(hold));
  dpch_top #(.MIN_PULSE_CYC(4), .DEBOUNCE_CYC(8), .COUNT_MAX(4)) dut (.clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .first_pulse_in(p1), .second_pulse_in(p2), .hold_in(hold), .clear_btn_in(clear_btn_in),
    .select_btn_in(select_btn_in), .dual_unit_in(dual_unit_in), .shown_count_out(cnt),
    .shown_second_out(sec), .shown_overflow_out(sovf), .first_overflow_out(ovf1),
    .second_overflow_out(ovf2));
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Holds one button for len cycles, then lets the debounce settle.
  task automatic press(input logic sel, input int len);
    @(posedge clk_in);
    if (sel) select_btn_in <= 1'h1;
    else clear_btn_in <= 1'h1;
    repeat (len) @(posedge clk_in);
    select_btn_in <= 1'h0;
    clear_btn_in <= 1'h0;
    repeat (30) @(posedge clk_in);
    #1;
  endtask
  task automatic t_count();
    repeat (3) sens.pulse(2'h1, 12);
    sens.pulse(2'h1, 2);
    repeat (2) sens.pulse(2'h2, 12);
    check("first count", cnt, 24'h3);
    press(1'h1, 24);
    check("shown second", sec, 24'h1);
    check("second count", cnt, 24'h2);
    press(1'h1, 24);
    check("back to first", cnt, 24'h3);
    $display("test count done");
  endtask
  task automatic t_bounce();
    press(1'h1, 3);
    check("bounce ignored", sec, 24'h0);
    $display("test bounce done");
  endtask
  task automatic t_hold();
    sens.set_hold(1'h1);
    sens.pulse(2'h3, 12);
    check("held count", cnt, 24'h3);
    sens.set_hold(1'h0);
    sens.pulse(2'h3, 12);
    check("resumed count", cnt, 24'h4);
    $display("test hold done");
  endtask
  // The first channel stands at its limit of 4; the next count wraps and flags.
  task automatic t_wrap();
    sens.pulse(2'h1, 12);
    check("wrapped count", cnt, 24'h0);
    check("wrap flags", {sovf, ovf1, ovf2}, 24'h6);
    sens.pulse(2'h1, 12);
    check("count after wrap", cnt, 24'h1);
    check("flags kept", {sovf, ovf1, ovf2}, 24'h6);
    $display("test wrap done");
  endtask
  task automatic t_clear();
    press(1'h0, 24);
    check("first cleared", cnt, 24'h0);
    check("flags cleared", {sovf, ovf1, ovf2}, 24'h0);
    press(1'h1, 24);
    check("second cleared", cnt, 24'h0);
    press(1'h1, 24);
    $display("test clear done");
  endtask
  task automatic t_single();
    @(posedge clk_in);
    dual_unit_in <= 1'h0;
    sens.pulse(2'h3, 12);
    check("single first", cnt, 24'h1);
    press(1'h1, 24);
    check("single fixed", sec, 24'h0);
    @(posedge clk_in);
    dual_unit_in <= 1'h1;
    press(1'h1, 24);
    check("second idle", cnt, 24'h0);
    $display("test single done");
  endtask
  // Cuts a hung run short.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    check("reset count", cnt, 24'h0);
    check("reset flags", {sec, sovf, ovf1, ovf2}, 24'h0);
    t_count();
    t_bounce();
    t_hold();
    t_wrap();
    t_clear();
    t_single();
    conclude();
  end
endmodule // tb_top
